/* File: hw/gldp_feeder.sv */
// feeder end: AHB-Lite registers that push descriptor bytes onto the stream
`timescale 1ns/1ps
module gldp_feeder
  import gldp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready
  output logic hresp, // always OKAY
  output logic [31:0] hrdata, // read data
  output logic irq, // level interrupt
  gldp_if.feeder lnk // byte stream out
);
  // ==========================================================
  // bus slave: one wait state, longer for a data write while a byte is pending
  logic ph_q;
  logic ph_wr_q;
  logic [7:0] ph_addr_q;
  logic exec;
  logic send;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic tx_last_q;
  gldp_fpos_e pos_q;
  logic [7:0] rem_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] ev;
  logic clr;

  assign exec = ph_q && !(ph_wr_q && ph_addr_q == OFF_DATA && tx_valid_q);
  assign send = tx_valid_q && lnk.byte_ready;
  assign clr = exec && !ph_wr_q && ph_addr_q == OFF_IRQ_STAT;
  assign hresp = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= 1'b0;
      ph_wr_q <= 1'b0;
      ph_addr_q <= 8'h00;
      hreadyout <= 1'b1;
    end else if (hsel && htrans[1] && hready) begin
      ph_q <= 1'b1;
      ph_wr_q <= hwrite;
      ph_addr_q <= haddr[7:0];
      hreadyout <= 1'b0;
    end else if (exec) begin
      ph_q <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (exec) begin
      hrdata <= 32'h00000000;
      if (!ph_wr_q) begin
        case (ph_addr_q)
          OFF_STATUS: hrdata <= {28'h0, 1'b0, pos_q, tx_valid_q};
          OFF_IRQ_STAT: hrdata <= 32'(irq_stat_q);
          OFF_IRQ_MASK: hrdata <= 32'(irq_mask_q);
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= IRQ_MASK_RST;
    end else if (exec && ph_wr_q && ph_addr_q == OFF_IRQ_MASK) begin
      irq_mask_q <= hwdata[IRQ_W-1:0];
    end
  end

  // ==========================================================
  // byte stream out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
    end else if (exec && ph_wr_q && ph_addr_q == OFF_DATA) begin
      tx_valid_q <= 1'b1;
      tx_data_q <= hwdata[7:0];
      tx_last_q <= hwdata[DATA_LAST_BIT];
    end else if (send) begin
      tx_valid_q <= 1'b0;
    end
  end
  assign lnk.byte_valid = tx_valid_q;
  assign lnk.byte_data = tx_data_q;
  assign lnk.byte_last = tx_last_q;

  // ==========================================================
  // descriptor framing seen from the sending side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= FP_TAG;
      rem_q <= 8'h00;
    end else if (send) begin
      case (pos_q)
        FP_TAG: pos_q <= FP_LEN;
        FP_LEN: begin
          rem_q <= tx_data_q;
          pos_q <= (tx_data_q == 8'h00) ? FP_TAG : FP_BODY;
        end
        FP_BODY: begin
          rem_q <= rem_q - 8'h01;
          if (rem_q == 8'h01) begin
            pos_q <= FP_TAG;
          end
        end
        default: pos_q <= FP_TAG;
      endcase
      if (tx_last_q) begin
        pos_q <= FP_TAG;
      end
    end
  end

  // ==========================================================
  // interrupts: read clears, a new event wins over the clear
  always_comb begin
    ev = '0;
    ev[IRQ_BYTE_SENT] = send;
    ev[IRQ_DESC_DONE] = send && ((pos_q == FP_LEN && tx_data_q == 8'h00) || (pos_q == FP_BODY && rem_q == 8'h01));
    ev[IRQ_STREAM_END] = send && tx_last_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (clr ? '0 : irq_stat_q) | ev;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule : gldp_feeder

/* File: hw/gldp_if.sv */
// interface: byte stream from the feeder to the parser
`timescale 1ns/1ps
interface gldp_if (
  input wire logic clk, // system clock
  input wire logic rst_n // async reset, active low
);
  logic byte_valid;
  logic [7:0] byte_data;
  logic byte_last;
  logic byte_ready;

  modport feeder (
    output byte_valid,
    output byte_data,
    output byte_last,
    input byte_ready
  );

  modport parser (
    input byte_valid,
    input byte_data,
    input byte_last,
    output byte_ready
  );
endinterface : gldp_if

/* File: hw/gldp_parser.sv */
// parser end: decodes guide linkage and counterpart descriptors from a byte stream
//
// Summary of operation
// - tag 0xCE selects guide linkage decoding
// - guide length byte bounds consumed bytes
// - third byte: two ones, 6-bit entry count
// - entry starts with 16-bit channel, MSB first
// - then 32-bit item key, MSB first
// - last entry byte: four ones, role code
// - emitter sends roles 0/1; others flagged
// - tag 0xCD selects counterpart decoding
// - counterpart length byte delimits descriptor
// - counterpart key output after four bytes
// - counterpart target listed in same table
// - guide descriptor only in proper loops
`timescale 1ns/1ps
module gldp_parser
  import gldp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  gldp_if.parser lnk, // byte stream in
  output logic busy, // inside a descriptor
  output logic [1:0] desc_kind, // kind of current or last descriptor
  output logic [5:0] link_entry_total, // entry count of guide descriptor
  output logic entry_valid, // one-cycle pulse: entry fields valid
  output logic [5:0] entry_index, // index of presented entry
  output logic [15:0] target_channel_number, // offline service of entry
  output logic [31:0] entry_item_key, // item key of entry
  output logic [3:0] entry_role, // raw role code
  output logic role_preview, // role decodes as preview
  output logic role_general, // role decodes as general description
  output logic cpart_valid, // one-cycle pulse: counterpart key valid
  output logic [31:0] cpart_item_key, // counterpart item key
  output logic desc_done, // pulse: descriptor fully consumed
  output logic err_role, // pulse: reserved role code
  output logic err_reserved, // pulse: reserved bits not all ones
  output logic err_length, // pulse: length disagrees with content
  output logic err_trunc // pulse: stream ended inside descriptor
);
  // ==========================================================
  // stream handshake
  logic ready_q;
  logic take;
  logic [7:0] b;
  logic body;
  logic fin;
  logic trunc;
  gldp_pstate_e state_q;
  logic [1:0] kind_q;
  logic [7:0] rem_q;
  logic [5:0] ent_left_q;
  logic [2:0] idx_q;
  logic [47:0] sh_q;
  logic [8:0] expect_len;

  // tag decode, shared by the walk and the kind output
  function automatic logic [1:0] tag_kind(input logic [7:0] t);
    if (t == TAG_GUIDE_LINK) begin
      return KIND_GUIDE;
    end else if (t == TAG_COUNTERPART) begin
      return KIND_CPART;
    end
    return KIND_OTHER;
  endfunction : tag_kind

  assign take = lnk.byte_valid && ready_q;
  assign b = lnk.byte_data;
  assign body = (state_q == PS_CNT) || (state_q == PS_ENTRY) || (state_q == PS_CPART) || (state_q == PS_SKIP);
  // descriptor ends when the declared count runs out
  assign fin = (body && rem_q == 8'h01) || (state_q == PS_LEN && b == 8'h00);
  assign trunc = lnk.byte_last && !fin;
  assign expect_len = 9'(CNT_HDR_BYTES) + 9'(b[5:0]) * 9'(ENTRY_BYTES);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
    end
  end
  assign lnk.byte_ready = ready_q;

  // ==========================================================
  // descriptor walk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PS_TAG;
      kind_q <= KIND_OTHER;
      rem_q <= 8'h00;
      ent_left_q <= 6'h00;
      idx_q <= 3'h0;
      sh_q <= 48'h0;
    end else if (take) begin
      if (body) begin
        rem_q <= rem_q - 8'h01;
      end
      case (state_q)
        PS_TAG: begin
          kind_q <= tag_kind(b);
          state_q <= PS_LEN;
        end
        PS_LEN: begin
          rem_q <= b;
          idx_q <= 3'h0;
          case (kind_q)
            KIND_GUIDE: state_q <= PS_CNT;
            KIND_CPART: state_q <= PS_CPART;
            default: state_q <= PS_SKIP;
          endcase
        end
        PS_CNT: begin
          ent_left_q <= b[5:0];
          state_q <= (b[5:0] == 6'h00) ? PS_SKIP : PS_ENTRY;
        end
        PS_ENTRY: begin
          sh_q <= {sh_q[39:0], b};
          if (idx_q == 3'(ENTRY_BYTES - 1)) begin
            idx_q <= 3'h0;
            ent_left_q <= ent_left_q - 6'h01;
            if (ent_left_q == 6'h01) begin
              state_q <= PS_SKIP;
            end
          end else begin
            idx_q <= idx_q + 3'h1;
          end
        end
        PS_CPART: begin
          sh_q <= {sh_q[39:0], b};
          idx_q <= idx_q + 3'h1;
          if (idx_q == 3'(CPART_BYTES - 1)) begin
            state_q <= PS_SKIP;
          end
        end
        PS_SKIP: begin
          state_q <= PS_SKIP;
        end
        default: begin
          state_q <= PS_TAG;
        end
      endcase
      if (fin || trunc) begin
        state_q <= PS_TAG;
      end
    end
  end

  // ==========================================================
  // descriptor-level outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      desc_kind <= KIND_OTHER;
      link_entry_total <= 6'h00;
      desc_done <= 1'b0;
      err_trunc <= 1'b0;
    end else begin
      desc_done <= take && fin;
      err_trunc <= take && trunc;
      if (take) begin
        busy <= !(fin || trunc);
        if (state_q == PS_TAG) begin
          desc_kind <= tag_kind(b);
        end
        if (state_q == PS_CNT) begin
          link_entry_total <= b[5:0];
        end
      end
    end
  end

  // ==========================================================
  // entry outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_valid <= 1'b0;
      entry_index <= 6'h00;
      target_channel_number <= 16'h0000;
      entry_item_key <= 32'h00000000;
      entry_role <= 4'h0;
      role_preview <= 1'b0;
      role_general <= 1'b0;
      err_role <= 1'b0;
    end else begin
      entry_valid <= 1'b0;
      err_role <= 1'b0;
      if (take && state_q == PS_ENTRY && idx_q == 3'(ENTRY_BYTES - 1)) begin
        entry_valid <= 1'b1;
        entry_index <= link_entry_total - ent_left_q;
        target_channel_number <= sh_q[47:32];
        entry_item_key <= sh_q[31:0];
        entry_role <= b[3:0];
        role_preview <= (b[3:0] == ROLE_PREVIEW);
        role_general <= (b[3:0] == ROLE_GENERAL);
        err_role <= (b[3:0] > ROLE_GENERAL);
      end
    end
  end

  // ==========================================================
  // counterpart output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpart_valid <= 1'b0;
      cpart_item_key <= 32'h00000000;
    end else begin
      cpart_valid <= 1'b0;
      if (take && state_q == PS_CPART && idx_q == 3'(CPART_BYTES - 1)) begin
        cpart_valid <= 1'b1;
        cpart_item_key <= {sh_q[23:0], b};
      end
    end
  end

  // ==========================================================
  // format checks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reserved <= 1'b0;
      err_length <= 1'b0;
    end else begin
      err_reserved <= 1'b0;
      err_length <= 1'b0;
      if (take) begin
        case (state_q)
          PS_LEN: begin
            // a guide descriptor needs its count byte, a counterpart its key
            err_length <= (kind_q == KIND_GUIDE && b == 8'h00) ||
                          (kind_q == KIND_CPART && b < 8'(CPART_BYTES));
          end
          PS_CNT: begin
            err_length <= (expect_len != {1'b0, rem_q});
            err_reserved <= (b[7:6] != CNT_RSV_ONES);
          end
          PS_ENTRY: begin
            if (idx_q == 3'(ENTRY_BYTES - 1)) begin
              err_reserved <= (b[7:4] != ROLE_RSV_ONES);
            end
          end
          default: begin
            err_reserved <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule : gldp_parser

/* File: hw/gldp_pkg.sv */
// package: constants and types for the guide link descriptor parser
package gldp_pkg;
  // descriptor type codes
  localparam logic [7:0] TAG_GUIDE_LINK = 8'hCE;
  localparam logic [7:0] TAG_COUNTERPART = 8'hCD;
  // guide linkage and counterpart layout
  localparam int ENTRY_BYTES = 7;
  localparam int CNT_HDR_BYTES = 1;
  localparam int CPART_BYTES = 4;
  localparam logic [1:0] CNT_RSV_ONES = 2'h3;
  localparam logic [3:0] ROLE_RSV_ONES = 4'hF;
  localparam logic [3:0] ROLE_PREVIEW = 4'h0;
  localparam logic [3:0] ROLE_GENERAL = 4'h1;
  // kind of descriptor being parsed
  localparam logic [1:0] KIND_OTHER = 2'h0;
  localparam logic [1:0] KIND_GUIDE = 2'h1;
  localparam logic [1:0] KIND_CPART = 2'h2;
  // feeder register offsets (byte addresses)
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  // data register fields
  localparam int DATA_LAST_BIT = 8;
  // irq status bit positions
  localparam int IRQ_BYTE_SENT = 0;
  localparam int IRQ_DESC_DONE = 1;
  localparam int IRQ_STREAM_END = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  // parser states
  typedef enum logic [2:0] {PS_TAG, PS_LEN, PS_CNT, PS_ENTRY, PS_CPART, PS_SKIP} gldp_pstate_e;
  // feeder position within a descriptor
  typedef enum logic [1:0] {FP_TAG, FP_LEN, FP_BODY} gldp_fpos_e;
endpackage : gldp_pkg

/* File: tb/gldp_monitor.sv */
// checker: byte stream and parser output assertions
`timescale 1ns/1ps
module gldp_monitor
  import gldp_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic byte_valid, // byte offered
  input wire logic [7:0] byte_data, // byte value
  input wire logic byte_ready, // parser ready
  input wire logic busy, // inside descriptor
  input wire logic [1:0] desc_kind, // descriptor kind
  input wire logic entry_valid, // entry pulse
  input wire logic [3:0] entry_role, // role code
  input wire logic role_preview, // preview
  input wire logic role_general, // general
  input wire logic err_role, // role error
  input wire logic cpart_valid, // key pulse
  input wire logic desc_done // done pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a taken byte outside a descriptor is a tag
  wire logic take_tag = byte_valid && byte_ready && !busy;
  // =====================================
  // assertions
  chk_ready_up: assert property ($past(rst_n) |-> byte_ready)
    else $error("parser not ready");
  chk_guide_kind: assert property (take_tag && byte_data == TAG_GUIDE_LINK |=> desc_kind == KIND_GUIDE)
    else $error("guide tag not decoded");
  chk_cpart_kind: assert property (take_tag && byte_data == TAG_COUNTERPART |=> desc_kind == KIND_CPART)
    else $error("counterpart tag not decoded");
  chk_other_kind: assert property (take_tag && byte_data != TAG_GUIDE_LINK && byte_data != TAG_COUNTERPART
    |=> desc_kind == KIND_OTHER)
    else $error("unknown tag not skipped");
  chk_role_map: assert property (entry_valid |-> role_preview == (entry_role == ROLE_PREVIEW)
    && role_general == (entry_role == ROLE_GENERAL))
    else $error("role decode wrong");
  chk_role_err: assert property (entry_valid |-> err_role == (entry_role > ROLE_GENERAL))
    else $error("role error flag wrong");
  chk_key_pulse: assert property (cpart_valid |=> !cpart_valid)
    else $error("key pulse too long");
  chk_done_idle: assert property (desc_done |-> !busy)
    else $error("busy after done");
  chk_kind_hold: assert property (busy && $past(busy) |-> $stable(desc_kind))
    else $error("kind changed inside descriptor");
  cov_entry: cover property (entry_valid && role_general);
  cov_cpart: cover property (cpart_valid);
  cov_role_err: cover property (err_role);
endmodule : gldp_monitor

/* File: tb/tb_top.sv */
// testbench: feeder and parser joined through the byte stream interface
`timescale 1ns/1ps
module tb_top;
  import gldp_pkg::*;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, irq, busy, entry_valid, role_preview, role_general;
  logic cpart_valid, desc_done, err_role, err_reserved, err_length, err_trunc;
  logic [31:0] haddr, hwdata, hrdata, rd, entry_item_key, cpart_item_key;
  logic [1:0] htrans, desc_kind;
  logic [2:0] hsize;
  logic [5:0] link_entry_total, entry_index;
  logic [15:0] target_channel_number;
  logic [3:0] entry_role;
  int err_count, num_checks, cyc, e_role, e_len, e_trunc, e_rsv, e_done;
  logic [31:0] ek[$], ck[$];
  logic [15:0] ech[$];
  logic [3:0] er[$];
  logic [5:0] ei[$];
  gldp_if lnk (.clk(clk), .rst_n(rst_n));
  gldp_feeder gldp_feeder_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .lnk(lnk));
  gldp_parser gldp_parser_i (.clk(clk), .rst_n(rst_n), .lnk(lnk), .busy(busy), .desc_kind(desc_kind),
    .link_entry_total(link_entry_total), .entry_valid(entry_valid), .entry_index(entry_index),
    .target_channel_number(target_channel_number), .entry_item_key(entry_item_key), .entry_role(entry_role),
    .role_preview(role_preview), .role_general(role_general), .cpart_valid(cpart_valid),
    .cpart_item_key(cpart_item_key), .desc_done(desc_done), .err_role(err_role),
    .err_reserved(err_reserved), .err_length(err_length), .err_trunc(err_trunc));
  gldp_monitor gldp_monitor_i (.clk(clk), .rst_n(rst_n), .byte_valid(lnk.byte_valid),
    .byte_data(lnk.byte_data), .byte_ready(lnk.byte_ready), .busy(busy), .desc_kind(desc_kind),
    .entry_valid(entry_valid), .entry_role(entry_role), .role_preview(role_preview),
    .role_general(role_general), .err_role(err_role), .cpart_valid(cpart_valid), .desc_done(desc_done));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // =====================================
  // capture of parser results, timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    e_role <= e_role + err_role;
    e_len <= e_len + err_length;
    e_rsv <= e_rsv + err_reserved;
    e_trunc <= e_trunc + err_trunc;
    e_done <= e_done + desc_done;
    if (cpart_valid) ck.push_back(cpart_item_key);
    if (entry_valid) begin
      ech.push_back(target_channel_number);
      ek.push_back(entry_item_key);
      er.push_back(entry_role);
      ei.push_back(entry_index);
    end
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  // =====================================
  // shared tasks
  task results;
    $display("err_count=%0d num_checks=%0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task cmp(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'(a);
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task send(input int n, input logic [135:0] v, input logic l);
    for (int i = n - 1; i >= 0; i--) begin
      ahb(1'b1, OFF_DATA, {23'h0, l && i == 0, v[8*i+:8]});
    end
    repeat (3) @(posedge clk);
  endtask : send
  // =====================================
  // scenarios
  task t_regs;
    ahb(1'b0, OFF_IRQ_MASK, 32'h0);
    cmp(32'(IRQ_MASK_RST), rd);
    ahb(1'b1, OFF_IRQ_MASK, 32'h5);
    ahb(1'b0, OFF_IRQ_MASK, 32'h0);
    cmp(32'h5, rd);
    ahb(1'b1, 8'h10, 32'hFF);
    ahb(1'b0, 8'h10, 32'h0);
    cmp(32'h0, rd);
    cmp(32'h0, 32'(hresp));
    ahb(1'b1, OFF_IRQ_MASK, 32'h0);
  endtask : t_regs
  task t_cpart;
    send(6, 48'hCD0411223344, 1'b0);
    cmp(32'h11223344, ck[0]);
    cmp(32'h1, 32'(e_done));
    cmp(32'(KIND_CPART), 32'(desc_kind));
    cmp(32'h0, 32'(irq));
  endtask : t_cpart
  task t_guide;
    send(17, 136'hCE0FC20005AABBCCDDF1123401020304F0, 1'b0);
    cmp(32'h2, 32'(link_entry_total));
    cmp(32'h0, 32'(ei[0]));
    cmp(32'h1, 32'(ei[1]));
    cmp(32'h5, 32'(ech[0]));
    cmp(32'hAABBCCDD, ek[0]);
    cmp(32'h1, 32'(er[0]));
    cmp(32'h1234, 32'(ech[1]));
    cmp(32'h01020304, ek[1]);
    cmp(32'h0, 32'(er[1]));
    cmp(32'h2, 32'({role_preview, role_general}));
    cmp(32'h0, 32'(e_len + e_role + e_rsv));
    cmp(32'(KIND_GUIDE), 32'(desc_kind));
  endtask : t_guide
  task t_other;
    send(5, 40'h5503CECD04, 1'b0);
    cmp(32'(KIND_OTHER), 32'(desc_kind));
    cmp(32'h2, 32'(ek.size()));
    cmp(32'h1, 32'(ck.size()));
    send(7, 56'hCD055566778899, 1'b0);
    cmp(32'h55667788, ck[1]);
    cmp(32'h2, 32'(ck.size()));
  endtask : t_other
  task t_irq;
    ahb(1'b1, OFF_IRQ_MASK, 32'h2);
    ahb(1'b0, OFF_IRQ_STAT, 32'h0);
    send(1, 8'hCD, 1'b0);
    ahb(1'b0, OFF_STATUS, 32'h0);
    cmp(32'h2, rd);
    cmp(32'h0, 32'(irq));
    send(5, 40'h040A0B0C0D, 1'b0);
    cmp(32'h0A0B0C0D, ck[2]);
    cmp(32'h1, 32'(irq));
    ahb(1'b0, OFF_IRQ_STAT, 32'h0);
    cmp(32'h2, rd & 32'h2);
    repeat (2) @(posedge clk);
    cmp(32'h0, 32'(irq));
  endtask : t_irq
  task t_errs;
    send(10, 80'hCE08C10005AABBCCDDF7, 1'b0);
    cmp(32'h1, 32'(e_role));
    send(11, 88'hCE09C10005AABBCCDDF100, 1'b0);
    cmp(32'h1, 32'(e_len));
    send(10, 80'hCE08410005AABBCCDDF1, 1'b0);
    cmp(32'h1, 32'(e_rsv));
    send(3, 24'hCE08C1, 1'b1);
    cmp(32'h1, 32'(e_trunc));
    cmp(32'h8, 32'(e_done));
  endtask : t_errs
  initial begin
    rst_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {err_count, num_checks, cyc, e_role, e_len, e_rsv, e_trunc, e_done} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_cpart;
    t_guide;
    t_other;
    t_irq;
    t_errs;
    results();
  end
endmodule : tb_top
